// ### rtl/charger_irq_sense_regs.sv
// Timer and boost flags, live sense registers and thermal mask register
`timescale 1ns/1ps
// What this block does
// [R1] Watchdog expiry latches timer flag bit three
// [R2] USB timer expiry latches timer flag bit two
// [R3] Charge timer expiry latches timer flag bit one
// [R4] Bit zero mirrors first register pending
// [R5] Boost bits three, two flag overload levels
// [R6] Boost bit one flags bus overvoltage
// [R7] Boost bit zero flags battery outside window
// [R8] Input sense shows live input comparators
// [R9] Input sense bit two shows charger present
// [R10] Battery sense shows live battery comparators
// [R11] Battery bit one shows current above end
// [R12] Temperature sense shows live die comparisons
// [R13] Thermal mask bits writable, mode entry keeps
// [R14] Bus range mask writable, boost mode entry clears
// [R15] Global mask high blocks every interrupt
// [R16] One-read flag clears on first read
// [R17] Two-read flag clears after condition gone
// [R18] Mask keeps flag from interrupt, flag latches
module charger_irq_sense_regs #(
	parameter logic [cisr_pkg::TIMER_W-1:0] WATCHDOG_LIMIT =
		cisr_pkg::TIMER_W'(cisr_pkg::WATCHDOG_CYCLES),
	parameter logic [cisr_pkg::TIMER_W-1:0] USB_LIMIT =
		cisr_pkg::TIMER_W'(cisr_pkg::USB_CYCLES),
	parameter logic [cisr_pkg::TIMER_W-1:0] CHARGE_LIMIT =
		cisr_pkg::TIMER_W'(cisr_pkg::CHARGE_CYCLES)
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Register port
	input  wire logic [7:0] regAddr,
	input  wire logic       regWrEn,
	input  wire logic       regRdEn,
	input  wire logic [7:0] regWrData,
	output logic      [7:0] regRdData,
	// Reset events from the charger state logic
	input  wire logic       offState,
	input  wire logic       registerReset,
	input  wire logic       timer_reset_event,
	input  wire logic       boost_mode_entry,
	input  wire logic       charge_mode_entry,
	input  wire logic       boostStartup,
	// Timer control
	input  wire logic       watchdogRun,
	input  wire logic       watchdogKick,
	input  wire logic       usbTimerRun,
	input  wire logic       usbTimerRestart,
	input  wire logic       chargeTimerRun,
	input  wire logic       chargeTimerRestart,
	// Live analog comparators
	input  wire logic       input_lockout_live,
	input  wire logic       input_above_bus_range_live,
	input  wire logic       input_below_bus_range_live,
	input  wire logic       input_detect_live,
	input  wire logic       charger_present_live,
	input  wire logic       bus_overload_live,
	input  wire logic       battery_overvoltage_live,
	input  wire logic       recharge_level_live,
	input  wire logic       reconnect_level_live,
	input  wire logic       precharge_level_live,
	input  wire logic       safe_level_live,
	input  wire logic       above_end_current_live,
	input  wire logic       die_shutdown_live,
	input  wire logic       die_second_threshold_live,
	input  wire logic       die_first_threshold_live,
	input  wire logic       die_warning_live,
	input  wire logic       capOverloadLive,
	input  wire logic       busOvervoltageLive,
	input  wire logic       batteryOutOfWindowLive,
	// Rest of the interrupt logic
	input  wire logic       first_charger_irq_summary,
	input  wire logic [5:0] statusFlags,
	input  wire logic [3:0] timerIrqMask,
	input  wire logic [3:0] boostIrqMask,
	input  wire logic       globalIrqMask,
	output logic      [7:0] thermalBusMask,
	output logic      [3:0] timerFlags,
	output logic      [3:0] boostFlags,
	output logic            irqRequest
);
	import cisr_pkg::*;

	cisr_state_t state_ff;
	cisr_state_t nxt_state;

	logic [LIVE_W-1:0]     liveRaw;
	logic [NUM_TIMERS-1:0] timerRun;
	logic [NUM_TIMERS-1:0] timerRestart;
	logic [NUM_TIMERS-1:0] timerExpire;
	logic [NUM_TIMERS-1:0] timerFlagBits;
	logic [3:0]            boostSet;
	logic [3:0]            boostClr;
	localparam logic [3:0] BOOST_DUAL = 4'hb;
	logic [3:0]            boostFlagBits;
	logic                  timerFlagClr;
	logic                  rdTimer;
	logic                  rdBoost;
	logic [7:0]            inputSense;
	logic [7:0]            batterySense;
	logic [7:0]            tempSense;
	logic [7:0]            timerReg;
	logic [7:0]            boostReg;
	logic [NUM_TIMERS-1:0][TIMER_W-1:0] timerLimit;

	// Address match on a strobe
	function automatic logic hit(input logic strobe, input logic [7:0] addr,
			input logic [7:0] ofs);
		hit = strobe && (addr == ofs);
	endfunction : hit

	// Comparator inputs gathered for synchronising
	assign liveRaw[LIVE_IN_LSB+5]  = input_lockout_live;
	assign liveRaw[LIVE_IN_LSB+4]  = input_above_bus_range_live;
	assign liveRaw[LIVE_IN_LSB+3]  = input_below_bus_range_live;
	assign liveRaw[LIVE_IN_LSB+2]  = input_detect_live;
	assign liveRaw[LIVE_IN_LSB+1]  = charger_present_live;
	assign liveRaw[LIVE_IN_LSB+0]  = bus_overload_live;
	assign liveRaw[LIVE_BAT_LSB+5] = battery_overvoltage_live;
	assign liveRaw[LIVE_BAT_LSB+4] = recharge_level_live;
	assign liveRaw[LIVE_BAT_LSB+3] = reconnect_level_live;
	assign liveRaw[LIVE_BAT_LSB+2] = precharge_level_live;
	assign liveRaw[LIVE_BAT_LSB+1] = safe_level_live;
	assign liveRaw[LIVE_BAT_LSB+0] = above_end_current_live;
	assign liveRaw[LIVE_TMP_LSB+3] = die_shutdown_live;
	assign liveRaw[LIVE_TMP_LSB+2] = die_second_threshold_live;
	assign liveRaw[LIVE_TMP_LSB+1] = die_first_threshold_live;
	assign liveRaw[LIVE_TMP_LSB+0] = die_warning_live;
	assign liveRaw[LIVE_BST_LSB+2] = capOverloadLive;
	assign liveRaw[LIVE_BST_LSB+1] = busOvervoltageLive;
	assign liveRaw[LIVE_BST_LSB+0] = batteryOutOfWindowLive;

	// Live sense registers, no reset of their own
	assign inputSense = {state_ff.liveSync[LIVE_IN_LSB+5], 1'b0,
		state_ff.liveSync[LIVE_IN_LSB+4:LIVE_IN_LSB+3], // [R8]
		state_ff.liveSync[LIVE_IN_LSB+2], // [R8]
		state_ff.liveSync[LIVE_IN_LSB+1], // [R9]
		state_ff.liveSync[LIVE_IN_LSB+0], 1'b0}; // [R8]
	assign batterySense = {1'b0,
		state_ff.liveSync[LIVE_BAT_LSB+5:LIVE_BAT_LSB+1], // [R10]
		state_ff.liveSync[LIVE_BAT_LSB+0], 1'b0}; // [R11]
	assign tempSense = {4'h0,
		state_ff.liveSync[LIVE_TMP_LSB+3:LIVE_TMP_LSB]}; // [R12]

	// Timers: index 0 charge, 1 usb, 2 watchdog
	assign timerLimit   = {WATCHDOG_LIMIT, USB_LIMIT, CHARGE_LIMIT};
	assign timerRun     = {watchdogRun, usbTimerRun, chargeTimerRun};
	assign timerRestart = {watchdogKick, usbTimerRestart, chargeTimerRestart};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_expire
			assign timerExpire[gi] = timerRun[gi] && !state_ff.timerDone[gi]
				&& !timerRestart[gi] && !timer_reset_event
				&& (state_ff.timerCnt[gi] == timerLimit[gi] - TIMER_W'(1));
		end
	endgenerate

	// Read strobes for the clear-on-read registers
	assign rdTimer = hit(regRdEn, regAddr, OFS_TIMER_FLAGS);
	assign rdBoost = hit(regRdEn, regAddr, OFS_BOOST_FLAGS);

	// Timer flags share one clear condition
	assign timerFlagClr = offState | registerReset | timer_reset_event
		| boost_mode_entry; // [R1] [R2] [R3]

	generate
		for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_timer_flag
			cisr_flag_cell #(
				.DUAL_READ (1'b0)
			) u_flag (
				.sys_clk  (sys_clk),
				.rst      (rst),
				.setCond  (timerExpire[gi]), // [R1] [R2] [R3]
				.clrEvent (timerFlagClr),
				.rdStrobe (rdTimer),
				.flag     (timerFlagBits[gi])
			);
		end
	endgenerate

	// Boost flag sources and clears
	assign boostSet[BIT_BUS_OVERLOAD_TWO] = state_ff.liveSync[LIVE_IN_LSB+0]; // [R5]
	assign boostSet[BIT_CAP_OVERLOAD_ONE] = state_ff.liveSync[LIVE_BST_LSB+2]; // [R5]
	assign boostSet[BIT_BUS_OVERVOLTAGE]  = state_ff.liveSync[LIVE_BST_LSB+1]; // [R6]
	assign boostSet[BIT_BATT_OUT_WINDOW]  = state_ff.liveSync[LIVE_BST_LSB+0]; // [R7]

	assign boostClr[BIT_BUS_OVERLOAD_TWO] = offState | registerReset
		| charge_mode_entry | boostStartup; // [R5]
	assign boostClr[BIT_CAP_OVERLOAD_ONE] = offState | registerReset
		| charge_mode_entry; // [R5]
	assign boostClr[BIT_BUS_OVERVOLTAGE]  = offState | registerReset
		| charge_mode_entry; // [R6]
	assign boostClr[BIT_BATT_OUT_WINDOW]  = offState | registerReset
		| charge_mode_entry; // [R7]

	// Only the capacitor overload flag clears on one read
	generate
		for (gi = 0; gi < 4; gi++) begin : g_boost_flag
			cisr_flag_cell #(
				.DUAL_READ (BOOST_DUAL[gi])
			) u_flag (
				.sys_clk  (sys_clk),
				.rst      (rst),
				.setCond  (boostSet[gi]),
				.clrEvent (boostClr[gi]),
				.rdStrobe (rdBoost),
				.flag     (boostFlagBits[gi])
			);
		end
	endgenerate

	// Register images
	always_comb begin
		timerReg = 8'h00;
		timerReg[BIT_WATCHDOG_EXPIRED] = timerFlagBits[2];
		timerReg[BIT_USB_EXPIRED]      = timerFlagBits[1];
		timerReg[BIT_CHARGE_EXPIRED]   = timerFlagBits[0];
		timerReg[BIT_FIRST_SUMMARY]    = first_charger_irq_summary; // [R4]
		boostReg = {4'h0, boostFlagBits};
	end

	// Next state
	always_comb begin
		nxt_state = state_ff;

		// Two-flop synchroniser for the comparators
		nxt_state.liveMeta = liveRaw;
		nxt_state.liveSync = state_ff.liveMeta;

		// Timers count while running, stop after expiry
		for (int i = 0; i < NUM_TIMERS; i++) begin
			if (timerRestart[i] || timer_reset_event || offState || registerReset) begin
				nxt_state.timerCnt[i]  = '0;
				nxt_state.timerDone[i] = 1'b0;
			end else if (timerExpire[i]) begin
				nxt_state.timerCnt[i]  = '0;
				nxt_state.timerDone[i] = 1'b1;
			end else if (timerRun[i] && !state_ff.timerDone[i]) begin
				nxt_state.timerCnt[i] = state_ff.timerCnt[i] + TIMER_W'(1);
			end
		end

		// Thermal and bus range mask register
		if (hit(regWrEn, regAddr, OFS_THERMAL_MASK)) begin
			nxt_state.maskBits = regWrData & MASK_WRITABLE; // [R13] [R14]
		end
		if (offState || registerReset) begin
			nxt_state.maskBits = MASK_RST_VALUE; // [R13] [R14]
		end else if (boost_mode_entry) begin
			nxt_state.maskBits = nxt_state.maskBits & ~MASK_BUS_RANGE; // [R14]
		end

		// Read data captured before the read clears flags
		if (regRdEn) begin
			unique case (regAddr)
				OFS_TIMER_FLAGS:  nxt_state.rdData = timerReg;
				OFS_BOOST_FLAGS:  nxt_state.rdData = boostReg;
				OFS_INPUT_SENSE:  nxt_state.rdData = inputSense;
				OFS_BATT_SENSE:   nxt_state.rdData = batterySense;
				OFS_TEMP_SENSE:   nxt_state.rdData = tempSense;
				OFS_THERMAL_MASK: nxt_state.rdData = state_ff.maskBits;
				default:          nxt_state.rdData = READ_UNMAPPED;
			endcase
		end

		// Interrupt request, masked flags still latch
		nxt_state.irq = !globalIrqMask && ( // [R15]
			|(timerReg[3:1] & ~timerIrqMask[3:1]) || // [R18]
			|(boostReg[3:0] & ~boostIrqMask) || // [R18]
			|({2'b00, statusFlags} & ~state_ff.maskBits
				& (MASK_THERMAL | MASK_BUS_RANGE))); // [R18]
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff          <= '0;
			state_ff.maskBits <= MASK_RST_VALUE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign regRdData      = state_ff.rdData;
	assign thermalBusMask = state_ff.maskBits;
	assign timerFlags     = timerReg[3:0];
	assign boostFlags     = boostReg[3:0];
	assign irqRequest     = state_ff.irq;

endmodule : charger_irq_sense_regs

// ### rtl/cisr_pkg.sv
// Constants and state types for the charger flag and sense registers
package cisr_pkg;

	// Register offsets
	localparam logic [7:0] OFS_TIMER_FLAGS  = 8'h05;
	localparam logic [7:0] OFS_BOOST_FLAGS  = 8'h06;
	localparam logic [7:0] OFS_INPUT_SENSE  = 8'h07;
	localparam logic [7:0] OFS_BATT_SENSE   = 8'h08;
	localparam logic [7:0] OFS_TEMP_SENSE   = 8'h09;
	localparam logic [7:0] OFS_THERMAL_MASK = 8'h0a;

	// Timer flag positions
	localparam int BIT_WATCHDOG_EXPIRED = 3;
	localparam int BIT_USB_EXPIRED      = 2;
	localparam int BIT_CHARGE_EXPIRED   = 1;
	localparam int BIT_FIRST_SUMMARY    = 0;

	// Boost flag positions
	localparam int BIT_BUS_OVERLOAD_TWO = 3;
	localparam int BIT_CAP_OVERLOAD_ONE = 2;
	localparam int BIT_BUS_OVERVOLTAGE  = 1;
	localparam int BIT_BATT_OUT_WINDOW  = 0;

	// Mask register layout and reset values
	localparam logic [7:0] MASK_WRITABLE   = 8'h3d;
	localparam logic [7:0] MASK_THERMAL    = 8'h3c;
	localparam logic [7:0] MASK_BUS_RANGE  = 8'h01;
	localparam logic [7:0] MASK_RST_VALUE  = 8'h00;
	localparam logic [7:0] READ_UNMAPPED   = 8'h00;

	// Live comparator vector layout
	localparam int LIVE_W       = 19;
	localparam int LIVE_IN_LSB  = 0;
	localparam int LIVE_BAT_LSB = 6;
	localparam int LIVE_TMP_LSB = 12;
	localparam int LIVE_BST_LSB = 16;

	// Timing
	localparam longint unsigned SYS_CLK_HZ         = 64'd50_000_000;
	localparam longint unsigned WATCHDOG_TIMEOUT_S = 64'd32;
	localparam longint unsigned USB_TIMEOUT_S      = 64'd2048;
	localparam longint unsigned CHARGE_TIMEOUT_S   = 64'd3600;
	localparam longint unsigned WATCHDOG_CYCLES    = WATCHDOG_TIMEOUT_S * SYS_CLK_HZ;
	localparam longint unsigned USB_CYCLES         = USB_TIMEOUT_S * SYS_CLK_HZ;
	localparam longint unsigned CHARGE_CYCLES      = CHARGE_TIMEOUT_S * SYS_CLK_HZ;
	localparam int              TIMER_W            = 38;
	localparam int              NUM_TIMERS         = 3;

	// Flag cell state
	typedef struct packed {
		logic flag;
		logic seen;
	} cisr_cell_t;

	// Register block state
	typedef struct packed {
		logic [LIVE_W-1:0]                   liveMeta;
		logic [LIVE_W-1:0]                   liveSync;
		logic [NUM_TIMERS-1:0][TIMER_W-1:0]  timerCnt;
		logic [NUM_TIMERS-1:0]               timerDone;
		logic [7:0]                          maskBits;
		logic [7:0]                          rdData;
		logic                                irq;
	} cisr_state_t;

endpackage : cisr_pkg

// ### rtl/cisr_flag_cell.sv
// One latched interrupt flag, cleared by one read or by two reads
`timescale 1ns/1ps
module cisr_flag_cell #(
	parameter bit DUAL_READ = 1'b0
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic setCond,
	input  wire logic clrEvent,
	input  wire logic rdStrobe,
	output logic      flag
);
	import cisr_pkg::*;

	cisr_cell_t cell_ff;
	cisr_cell_t nxt_cell;

	always_comb begin
		nxt_cell = cell_ff;
		if (DUAL_READ) begin
			if (setCond) begin
				// Condition still present keeps flag, read only arms it
				nxt_cell.flag = 1'b1; // [R17]
				nxt_cell.seen = cell_ff.seen | rdStrobe;
			end else if (clrEvent) begin
				nxt_cell = '0;
			end else if (rdStrobe && cell_ff.flag) begin
				if (cell_ff.seen) begin
					nxt_cell = '0; // [R17]
				end else begin
					nxt_cell.seen = 1'b1;
				end
			end
		end else begin
			nxt_cell.seen = 1'b0;
			if (setCond) begin
				nxt_cell.flag = 1'b1; // [R16]
			end else if (clrEvent || rdStrobe) begin
				nxt_cell.flag = 1'b0; // [R16]
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cell_ff <= '0;
		end else begin
			cell_ff <= nxt_cell;
		end
	end

	assign flag = cell_ff.flag;

endmodule : cisr_flag_cell

// ### testbench/cisr_properties.sv
// Concurrent checks on the flag and mask register ports and the interrupt request
`timescale 1ns/1ps
module cisr_properties (
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic [7:0] regAddr,
	input wire logic       regWrEn,
	input wire logic       regRdEn,
	input wire logic [7:0] regWrData,
	input wire logic [7:0] regRdData,
	input wire logic       offState,
	input wire logic       registerReset,
	input wire logic       boost_mode_entry,
	input wire logic       charge_mode_entry,
	input wire logic       boostStartup,
	input wire logic       bus_overload_live,
	input wire logic       capOverloadLive,
	input wire logic       busOvervoltageLive,
	input wire logic       batteryOutOfWindowLive,
	input wire logic       first_charger_irq_summary,
	input wire logic [5:0] statusFlags,
	input wire logic [3:0] timerIrqMask,
	input wire logic [3:0] boostIrqMask,
	input wire logic       globalIrqMask,
	input wire logic [7:0] thermalBusMask,
	input wire logic [3:0] timerFlags,
	input wire logic [3:0] boostFlags,
	input wire logic       irqRequest
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// Boost conditions low long enough to pass the synchroniser
	sequence boostQuiet;
		(!bus_overload_live && !capOverloadLive && !busOvervoltageLive
			&& !batteryOutOfWindowLive)[*4];
	endsequence
	mask_write_a: assert property (
		regWrEn && regAddr == 8'h0a && !offState && !registerReset && !boost_mode_entry
		|=> thermalBusMask == ($past(regWrData) & 8'h3d)) else $error("mask write wrong");
	mask_clear_a: assert property (offState || registerReset |=> thermalBusMask == 8'h00)
		else $error("mask not cleared");
	otg_entry_a: assert property (
		boost_mode_entry && !regWrEn && !offState && !registerReset
		|=> thermalBusMask == {$past(thermalBusMask[7:1]), 1'b0}) else $error("otg mask wrong");
	summary_bit_a: assert property (regRdEn && regAddr == 8'h05
		|=> regRdData[7:4] == 4'h0 && regRdData[0] == $past(first_charger_irq_summary))
		else $error("summary bit wrong");
	global_block_a: assert property (globalIrqMask |=> !irqRequest)
		else $error("irq despite global mask");
	irq_raise_a: assert property (
		!globalIrqMask && timerFlags[3] && !timerIrqMask[3] |=> irqRequest)
		else $error("irq not raised");
	mask_quiet_a: assert property (
		timerIrqMask[3:1] == 3'h7 && boostIrqMask == 4'hf
		&& (statusFlags & ~thermalBusMask[5:0] & 6'h3d) == 6'h00 |=> !irqRequest)
		else $error("masked irq raised");
	boost_clear_a: assert property (
		boostQuiet ##0 (offState || registerReset || charge_mode_entry)
		|=> boostFlags == 4'h0) else $error("boost flags not cleared");
	startup_clear_a: assert property (boostQuiet ##0 boostStartup |=> !boostFlags[3])
		else $error("overload flag not cleared");
endmodule : cisr_properties

// ### testbench/cisr_host.sv
// Host side of the register port
`timescale 1ns/1ps
module cisr_host (
	input  wire logic       sys_clk,
	input  wire logic [7:0] regRdData,
	output logic      [7:0] regAddr,
	output logic            regWrEn,
	output logic            regRdEn,
	output logic      [7:0] regWrData
);
	initial begin
		{regAddr, regWrEn, regRdEn, regWrData} = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] dat);
		@(negedge sys_clk);
		regAddr = a;
		regWrData = dat;
		regWrEn = 1'b1;
		@(negedge sys_clk);
		regWrEn = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] dat);
		@(negedge sys_clk);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge sys_clk);
		regRdEn = 1'b0;
		dat = regRdData;
	endtask : rd
endmodule : cisr_host

// ### testbench/tb_charger_irq_sense_regs.sv
// Top bench for the flag, sense and mask registers
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_charger_irq_sense_regs;
	logic        sys_clk, rst, regWrEn, regRdEn, globalIrqMask, irqRequest;
	logic        first_charger_irq_summary, tmrRun, tmrRestart;
	logic [7:0]  regAddr, regWrData, regRdData, thermalBusMask, d;
	logic [3:0]  timerIrqMask, boostIrqMask, timerFlags, boostFlags;
	logic [5:0]  statusFlags, ev;
	logic [18:0] live;
	logic [23:0] exp;
	int          checks = 0;
	int          mismatches = 0;
	int          tmrEv [5] = '{0, 0, 1, 2, 3};
	int          bstEv [4] = '{5, 0, 1, 4};
	logic [18:0] pats [3] = '{19'h0ffff, 19'h0aaaa, 19'h05555};
	charger_irq_sense_regs #(.WATCHDOG_LIMIT(38'd10), .USB_LIMIT(38'd20),
		.CHARGE_LIMIT(38'd30)) u_charger_irq_sense_regs (.*,
		.offState(ev[0]), .registerReset(ev[1]), .timer_reset_event(ev[2]),
		.boost_mode_entry(ev[3]), .charge_mode_entry(ev[4]), .boostStartup(ev[5]),
		.watchdogRun(tmrRun), .usbTimerRun(tmrRun), .chargeTimerRun(tmrRun),
		.watchdogKick(tmrRestart), .usbTimerRestart(tmrRestart),
		.chargeTimerRestart(tmrRestart),
		.input_lockout_live(live[0]), .input_above_bus_range_live(live[1]),
		.input_below_bus_range_live(live[2]), .input_detect_live(live[3]),
		.charger_present_live(live[4]), .bus_overload_live(live[5]),
		.battery_overvoltage_live(live[6]), .recharge_level_live(live[7]),
		.reconnect_level_live(live[8]), .precharge_level_live(live[9]),
		.safe_level_live(live[10]), .above_end_current_live(live[11]),
		.die_shutdown_live(live[12]), .die_second_threshold_live(live[13]),
		.die_first_threshold_live(live[14]), .die_warning_live(live[15]),
		.capOverloadLive(live[16]), .busOvervoltageLive(live[17]),
		.batteryOutOfWindowLive(live[18]));
	cisr_host u_cisr_host (.*);
	function automatic logic [23:0] senseExp(input logic [18:0] l);
		return {l[0], 1'b0, l[1], l[2], l[3], l[4], l[5], 1'b0, 1'b0, l[6], l[7], l[8],
			l[9], l[10], l[11], 1'b0, 4'h0, l[12], l[13], l[14], l[15]};
	endfunction : senseExp
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	task automatic pulse(input int k);
		@(negedge sys_clk) ev[k] = 1'b1;
		@(negedge sys_clk) ev[k] = 1'b0;
	endtask : pulse
	task automatic waitIrq(input logic e);
		int n = 0;
		while (irqRequest !== e && n < 8) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK(irqRequest, e)
		if (n == 8)
			report_and_stop();
	endtask : waitIrq
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		#100us;
		mismatches++;
		report_and_stop();
	end
	initial begin
		rst = 1'b1;
		{live, ev, tmrRun, tmrRestart, statusFlags, timerIrqMask, boostIrqMask} = '0;
		globalIrqMask = 1'b0;
		first_charger_irq_summary = 1'b1;
		repeat (6) @(negedge sys_clk);
		rst = 1'b0;
		u_cisr_host.rd(8'h0a, d);
		`CHK(d, 8'h00)
		u_cisr_host.wr(8'h0a, 8'hff);
		u_cisr_host.wr(8'h07, 8'h00);
		u_cisr_host.rd(8'h0a, d);
		`CHK(d, 8'h3d)
		u_cisr_host.rd(8'h0b, d);
		`CHK(d, 8'h00)
		pulse(3);
		`CHK(thermalBusMask, 8'h3c)
		pulse(0);
		`CHK(thermalBusMask, 8'h00)
		u_cisr_host.wr(8'h0a, 8'h3d);
		pulse(1);
		`CHK(thermalBusMask, 8'h00)
		for (int i = 0; i < 3; i++) begin
			live = pats[i];
			repeat (3) @(negedge sys_clk);
			exp = senseExp(pats[i]);
			u_cisr_host.rd(8'h07, d);
			`CHK(d, exp[23:16])
			u_cisr_host.rd(8'h08, d);
			`CHK(d, exp[15:8])
			u_cisr_host.rd(8'h09, d);
			`CHK(d, exp[7:0])
		end
		live = '0;
		for (int k = 0; k < 5; k++) begin
			@(negedge sys_clk) tmrRestart = 1'b1;
			@(negedge sys_clk) tmrRestart = 1'b0;
			tmrRun = 1'b1;
			repeat (13) @(negedge sys_clk);
			`CHK(timerFlags, 4'h9)
			repeat (22) @(negedge sys_clk);
			tmrRun = 1'b0;
			`CHK(timerFlags, 4'hf)
			if (k == 0) begin
				u_cisr_host.rd(8'h05, d);
				`CHK(d, 8'h0f)
				u_cisr_host.rd(8'h05, d);
				`CHK(d, 8'h01)
			end else begin
				pulse(tmrEv[k]);
				`CHK(timerFlags, 4'h1)
			end
		end
		first_charger_irq_summary = 1'b0;
		u_cisr_host.rd(8'h05, d);
		`CHK(d, 8'h00)
		pulse(1);
		live[16] = 1'b1;
		repeat (3) @(negedge sys_clk);
		live[16] = 1'b0;
		repeat (4) @(negedge sys_clk);
		u_cisr_host.rd(8'h06, d);
		`CHK(d, 8'h04)
		u_cisr_host.rd(8'h06, d);
		`CHK(d, 8'h00)
		live[17] = 1'b1;
		repeat (4) @(negedge sys_clk);
		u_cisr_host.rd(8'h06, d);
		u_cisr_host.rd(8'h06, d);
		`CHK(d, 8'h02)
		live[17] = 1'b0;
		repeat (4) @(negedge sys_clk);
		u_cisr_host.rd(8'h06, d);
		u_cisr_host.rd(8'h06, d);
		`CHK(d, 8'h00)
		for (int j = 0; j < 4; j++) begin
			live = 19'h70020;
			repeat (3) @(negedge sys_clk);
			live = '0;
			repeat (4) @(negedge sys_clk);
			`CHK(boostFlags, 4'hf)
			pulse(bstEv[j]);
			`CHK(boostFlags, (j == 0) ? 4'h7 : 4'h0)
		end
		statusFlags = 6'h20;
		waitIrq(1'b1);
		timerIrqMask = 4'he;
		boostIrqMask = 4'hf;
		u_cisr_host.wr(8'h0a, 8'h20);
		waitIrq(1'b0);
		u_cisr_host.wr(8'h0a, 8'h00);
		waitIrq(1'b1);
		globalIrqMask = 1'b1;
		waitIrq(1'b0);
		report_and_stop();
	end
endmodule : tb_charger_irq_sense_regs
bind charger_irq_sense_regs cisr_properties u_cisr_properties (.*);
